/* rtl/tcd_decoder.sv */
// command layer of a single line thermometer slave with apb register access
//
// Summary of operation
// R01 - read rom sends whole 64-bit identifier
// R02 - match rom compares 64 bits, exact match addresses
// R03 - mismatch ignores bus until next reset
// R04 - skip rom addresses device without identifier
// R05 - master avoids multi-slave skip then read
// R06 - alarm search only with alarm flag set
// R07 - master reinitialises after each alarm search
// R08 - convert starts conversion, result into bytes 0-1
// R09 - master strong pullup during parasite conversion
// R10 - external supply: status 0 busy, 1 done
// R11 - write scratchpad bytes go to bytes 2, 3
// R12 - master sends both bytes before reset
// R13 - read scratchpad sends bytes 0 through 8
// R14 - reset abandons scratchpad read at any point
// R15 - copy writes trigger bytes to nonvolatile store
// R16 - master strong pullup 10 ms during copy
// R17 - reload triggers, status 0 busy, 1 done
// R18 - trigger reload runs automatically at power-up
// R19 - power query: parasite pulls low, else high
// R20 - master quiet during strong pullup
// R21 - master starts every slot except presence
// R22 - order: reset, rom command, function command
// R23 - all bytes least significant bit first
// R24 - rom commands are 8 bits, five defined
// R25 - undefined command waits for next reset
// R26 - bus reset returns decoder to rom stage
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/100ps
`include "tcd_params.svh"

module tcd_decoder (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic bus_reset,
	input wire logic wr_bit_valid,
	input wire logic wr_bit,
	input wire logic rd_slot,
	output logic rd_bit,
	input wire logic alarm_flag,
	output logic search_start,
	output logic search_alarm,
	output logic conv_start,
	input wire logic conv_busy,
	input wire logic temp_valid,
	input wire logic [15:0] temp_data,
	output logic copy_start,
	output logic [7:0] copy_th,
	output logic [7:0] copy_tl,
	input wire logic [7:0] nv_th,
	input wire logic [7:0] nv_tl,
	input wire logic [7:0] crc_in,
	output tcd_pkg::tcd_state_t dec_state
);
	import tcd_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [31:0] ctrl; // control, bit 0 parasite mode
	logic [63:0] dev_id; // device identifier
	logic [7:0] last_cmd; // last decoded command code
	tcd_state_t state; // decoder state
	tcd_state_t next_state;
	tcd_stat_sel_t stat_sel; // operation reported in status slots
	logic [7:0] rx_byte; // receive shift register
	logic [6:0] bit_cnt; // bits seen in current field
	logic [3:0] byte_cnt; // bytes done in current transfer
	logic id_miss; // identifier mismatch seen
	logic [7:0] tx_byte; // transmit shift register
	logic [1:0] recall_step; // 0 idle, 1 byte 2, 2 byte 3
	logic temp_lo_pend; // temperature low byte not yet stored
	logic temp_hi_pend; // temperature high byte not yet stored
	logic [15:0] temp_q; // held temperature result
	logic [7:0] th_q; // mirror of scratchpad byte 2
	logic [7:0] tl_q; // mirror of scratchpad byte 3
	logic mem_we;
	logic [3:0] mem_waddr;
	logic [7:0] mem_wdata;
	logic [3:0] mem_raddr;
	logic [7:0] mem_rdata;
	logic [7:0] rx_full; // byte including the bit arriving now
	logic byte_done; // eighth bit arriving now
	logic spad_wr; // trigger byte from the line this cycle
	logic next_rd_bit;
	logic recall_busy;
	logic parasite;
	logic setup;
	logic [31:0] next_prdata;
	logic next_pslverr;

	assign parasite = ctrl[`TCD_CTRL_PARASITE];
	assign recall_busy = (recall_step != 2'd0);
	assign rx_full = {wr_bit, rx_byte[7:1]}; // R23
	assign byte_done = wr_bit_valid && (bit_cnt[2:0] == 3'd7);
	assign spad_wr = (state == TCD_ST_WRITE_SPAD) && byte_done;
	assign dec_state = state;

	// ----------------------------------------------------------------
	// scratchpad store
	// ----------------------------------------------------------------
	tcd_spad_mem u_spad (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(mem_we),
		.wr_addr(mem_waddr),
		.wr_data(mem_wdata),
		.rd_addr(mem_raddr),
		.rd_data(mem_rdata)
	);

	// prefetch the byte after the one being sent, byte 0 otherwise
	assign mem_raddr = (state == TCD_ST_READ_SPAD) ? byte_cnt + 4'd1 : 4'd0;

	// write arbiter: line data, then reload, then temperature
	always_comb begin
		mem_we = 1'b1;
		mem_waddr = 4'd0;
		mem_wdata = 8'h00;
		if (spad_wr) begin
			mem_waddr = (byte_cnt == 4'd0) ? `TCD_SPAD_TH : `TCD_SPAD_TL; // R11
			mem_wdata = rx_full;
		end else if (recall_step == 2'd1) begin
			mem_waddr = `TCD_SPAD_TH; // R17
			mem_wdata = nv_th;
		end else if (recall_step == 2'd2) begin
			mem_waddr = `TCD_SPAD_TL; // R17
			mem_wdata = nv_tl;
		end else if (temp_lo_pend) begin
			mem_waddr = `TCD_SPAD_TEMP_LO; // R08
			mem_wdata = temp_q[7:0];
		end else if (temp_hi_pend) begin
			mem_waddr = `TCD_SPAD_TEMP_HI; // R08
			mem_wdata = temp_q[15:8];
		end else begin
			mem_we = 1'b0;
		end
	end

	// trigger mirrors follow every write to bytes 2 and 3
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			th_q <= 8'hff;
			tl_q <= 8'hff;
		end else if (mem_we && mem_waddr == `TCD_SPAD_TH) begin
			th_q <= mem_wdata;
		end else if (mem_we && mem_waddr == `TCD_SPAD_TL) begin
			tl_q <= mem_wdata;
		end
	end

	// ----------------------------------------------------------------
	// temperature capture and trigger reload
	// ----------------------------------------------------------------
	// result held until both bytes are stored; a new result wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			temp_q <= 16'h0000;
			temp_lo_pend <= 1'b0;
			temp_hi_pend <= 1'b0;
		end else if (temp_valid) begin
			temp_q <= temp_data; // R08
			temp_lo_pend <= 1'b1;
			temp_hi_pend <= 1'b1;
		end else if (mem_we && mem_waddr == `TCD_SPAD_TEMP_LO && temp_lo_pend) begin
			temp_lo_pend <= 1'b0;
		end else if (mem_we && mem_waddr == `TCD_SPAD_TEMP_HI && temp_hi_pend) begin
			temp_hi_pend <= 1'b0;
		end
	end

	// reload starts by itself out of reset, or on command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			recall_step <= 2'd1; // R18
		end else if (recall_step == 2'd1 && !spad_wr) begin
			recall_step <= 2'd2;
		end else if (recall_step == 2'd2 && !spad_wr) begin
			recall_step <= 2'd0;
		end else if (state == TCD_ST_FUNC && byte_done
			&& rx_full == `TCD_RELOAD_TRIGGERS_CMD) begin
			recall_step <= 2'd1; // R17
		end
	end

	// ----------------------------------------------------------------
	// command state machine
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			TCD_ST_WAIT_RESET: begin
				next_state = state; // R03 R25
			end
			TCD_ST_ROM: begin
				if (byte_done) begin
					unique case (rx_full) // R24
						`TCD_ROM_READ: next_state = TCD_ST_READ_ID; // R01
						`TCD_ROM_MATCH: next_state = TCD_ST_MATCH; // R02
						`TCD_ROM_SKIP: next_state = TCD_ST_FUNC; // R04
						default: next_state = TCD_ST_WAIT_RESET; // R22 R25
					endcase
				end
			end
			TCD_ST_READ_ID: begin
				if (rd_slot && bit_cnt == `TCD_ID_BITS - 7'd1) begin
					next_state = TCD_ST_FUNC; // R01
				end
			end
			TCD_ST_MATCH: begin
				if (wr_bit_valid && bit_cnt == `TCD_ID_BITS - 7'd1) begin
					if (id_miss || wr_bit != dev_id[63]) begin
						next_state = TCD_ST_WAIT_RESET; // R03
					end else begin
						next_state = TCD_ST_FUNC; // R02
					end
				end
			end
			TCD_ST_FUNC: begin
				if (byte_done) begin
					unique case (rx_full)
						`TCD_FN_CONVERT: next_state = TCD_ST_STATUS; // R10
						`TCD_FN_WRITE_SPAD: next_state = TCD_ST_WRITE_SPAD; // R11
						`TCD_FN_READ_SPAD: next_state = TCD_ST_READ_SPAD; // R13
						`TCD_RELOAD_TRIGGERS_CMD: next_state = TCD_ST_STATUS; // R17
						`TCD_FN_POWER_QUERY: next_state = TCD_ST_POWER; // R19
						default: next_state = TCD_ST_WAIT_RESET; // R15 R25
					endcase
				end
			end
			TCD_ST_WRITE_SPAD: begin
				if (spad_wr && byte_cnt == 4'd1) begin
					next_state = TCD_ST_WAIT_RESET;
				end
			end
			TCD_ST_READ_SPAD, TCD_ST_STATUS, TCD_ST_POWER: begin
				next_state = state; // left only by a bus reset
			end
		endcase
		if (bus_reset) begin
			next_state = TCD_ST_ROM; // R14 R22 R26
		end
	end

	// state register, silent until the first bus reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= TCD_ST_WAIT_RESET;
		end else begin
			state <= next_state;
		end
	end

	// bit and byte counters, cleared on every state change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_cnt <= 7'd0;
			byte_cnt <= 4'd0;
		end else if (next_state != state || bus_reset) begin // R26
			bit_cnt <= 7'd0;
			byte_cnt <= 4'd0;
		end else if (wr_bit_valid || (rd_slot && state == TCD_ST_READ_ID)) begin
			bit_cnt <= bit_cnt + 7'd1;
			if (byte_done) begin
				byte_cnt <= byte_cnt + 4'd1;
			end
		end else if (rd_slot && state == TCD_ST_READ_SPAD) begin
			bit_cnt <= bit_cnt + 7'd1;
			if (bit_cnt[2:0] == 3'd7 && byte_cnt < `TCD_SPAD_BYTES) begin
				byte_cnt <= byte_cnt + 4'd1; // R13
			end
		end
	end

	// receive shifter, lsb arrives first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_byte <= 8'h00;
		end else if (wr_bit_valid) begin
			rx_byte <= rx_full; // R23
		end
	end

	// identifier compare, one bit per write slot
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			id_miss <= 1'b0;
		end else if (state != TCD_ST_MATCH) begin
			id_miss <= 1'b0;
		end else if (wr_bit_valid && wr_bit != dev_id[bit_cnt[5:0]]) begin
			id_miss <= 1'b1; // R02
		end
	end

	// transmit shifter for the scratchpad, byte 8 is the crc
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_byte <= 8'hff;
		end else if (state == TCD_ST_FUNC && next_state == TCD_ST_READ_SPAD) begin
			tx_byte <= mem_rdata; // R13
		end else if (state == TCD_ST_READ_SPAD && rd_slot) begin
			if (bit_cnt[2:0] != 3'd7) begin
				tx_byte <= {1'b1, tx_byte[7:1]}; // R23
			end else if (byte_cnt + 4'd1 == `TCD_SPAD_CRC) begin
				tx_byte <= crc_in;
			end else begin
				tx_byte <= mem_rdata;
			end
		end
	end

	// last command and the operation that status slots report
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_cmd <= 8'h00;
			stat_sel <= TCD_SEL_CONV;
		end else if (byte_done && (state == TCD_ST_ROM || state == TCD_ST_FUNC)) begin
			last_cmd <= rx_full;
			stat_sel <= (rx_full == `TCD_FN_CONVERT) ? TCD_SEL_CONV : TCD_SEL_RECALL;
		end
	end

	// ----------------------------------------------------------------
	// one cycle command pulses, the search_alarm qualifier and the copy bytes to the neighbouring engines
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			search_start <= 1'b0;
			search_alarm <= 1'b0;
			conv_start <= 1'b0;
			copy_start <= 1'b0;
			copy_th <= 8'h00;
			copy_tl <= 8'h00;
		end else begin
			search_start <= state == TCD_ST_ROM && byte_done && !bus_reset
				&& (rx_full == `TCD_ROM_SEARCH
				|| (rx_full == `TCD_ROM_ALARM_SEARCH && alarm_flag)); // R06 R22
			search_alarm <= rx_full == `TCD_ROM_ALARM_SEARCH; // R06
			conv_start <= state == TCD_ST_FUNC && byte_done && !bus_reset
				&& rx_full == `TCD_FN_CONVERT; // R08
			copy_start <= state == TCD_ST_FUNC && byte_done && !bus_reset
				&& rx_full == `TCD_FN_COPY; // R15
			copy_th <= th_q; // R15
			copy_tl <= tl_q;
		end
	end

	// ----------------------------------------------------------------
	// level offered to the next read slot
	// ----------------------------------------------------------------
	always_comb begin
		next_rd_bit = 1'b1; // released line reads as 1
		unique case (state)
			TCD_ST_READ_ID: next_rd_bit = dev_id[bit_cnt[5:0]]; // R01 R23
			TCD_ST_READ_SPAD: next_rd_bit = (byte_cnt < `TCD_SPAD_BYTES) ? tx_byte[0] : 1'b1;
			TCD_ST_STATUS: begin
				if (stat_sel == TCD_SEL_CONV) begin
					next_rd_bit = parasite || !conv_busy; // R10
				end else begin
					next_rd_bit = !recall_busy; // R17
				end
			end
			TCD_ST_POWER: next_rd_bit = !parasite; // R19
			TCD_ST_WAIT_RESET, TCD_ST_ROM, TCD_ST_MATCH, TCD_ST_FUNC,
			TCD_ST_WRITE_SPAD: next_rd_bit = 1'b1; // R21
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_bit <= 1'b1;
		end else begin
			rd_bit <= next_rd_bit;
		end
	end

	// ----------------------------------------------------------------
	// apb slave, no wait states, read data taken in setup
	// ----------------------------------------------------------------
	assign setup = psel && !penable;
	assign pready = 1'b1;

	// software writes, at the access edge only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= `TCD_CTRL_RESET;
			dev_id <= `TCD_ID_RESET;
		end else if (psel && penable && pwrite) begin
			unique case (paddr)
				`TCD_OFS_CTRL: ctrl <= {31'h0, pwdata[`TCD_CTRL_PARASITE]};
				`TCD_OFS_ID_LO: dev_id[31:0] <= pwdata;
				`TCD_OFS_ID_HI: dev_id[63:32] <= pwdata;
				default: ctrl <= ctrl;
			endcase
		end
	end

	// read mux and error decode
	always_comb begin
		next_prdata = 32'h0000_0000;
		next_pslverr = 1'b0;
		unique case (paddr)
			`TCD_OFS_CTRL: next_prdata = ctrl;
			`TCD_OFS_ID_LO: next_prdata = dev_id[31:0];
			`TCD_OFS_ID_HI: next_prdata = dev_id[63:32];
			`TCD_OFS_STATUS: begin
				next_prdata[8:0] = state;
				next_prdata[`TCD_STAT_RECALL_BUSY] = recall_busy;
				next_prdata[`TCD_STAT_CONV_BUSY] = conv_busy;
				next_prdata[`TCD_STAT_CMD_LSB +: 8] = last_cmd;
			end
			`TCD_OFS_TRIG: next_prdata[15:0] = {tl_q, th_q};
			default: next_pslverr = 1'b1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata <= pwrite ? 32'h0000_0000 : next_prdata;
			pslverr <= next_pslverr;
		end
	end

endmodule

/* rtl/tcd_params.svh */
// offsets, field positions, reset values and command codes of the thermometer command decoder
`ifndef TCD_PARAMS_SVH
`define TCD_PARAMS_SVH

// ----------------------------------------------------------------
// apb register byte offsets
// ----------------------------------------------------------------
`define TCD_OFS_CTRL 12'h000
`define TCD_OFS_ID_LO 12'h004
`define TCD_OFS_ID_HI 12'h008
`define TCD_OFS_STATUS 12'h00c
`define TCD_OFS_TRIG 12'h010

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TCD_CTRL_PARASITE 0
`define TCD_STAT_RECALL_BUSY 12
`define TCD_STAT_CONV_BUSY 13
`define TCD_STAT_CMD_LSB 16

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TCD_CTRL_RESET 32'h0000_0000
`define TCD_ID_RESET 64'h0000_0000_0000_0000
`define TCD_SPAD_RESET 72'h00_ff_ff_00_00_00_00_00_00

// ----------------------------------------------------------------
// rom level command codes
// ----------------------------------------------------------------
`define TCD_ROM_READ 8'h33
`define TCD_ROM_MATCH 8'h55
`define TCD_ROM_SKIP 8'hcc
`define TCD_ROM_SEARCH 8'hf0
`define TCD_ROM_ALARM_SEARCH 8'hec

// ----------------------------------------------------------------
// function command codes
// ----------------------------------------------------------------
`define TCD_FN_CONVERT 8'h44
`define TCD_FN_WRITE_SPAD 8'h4e
`define TCD_FN_READ_SPAD 8'hbe
`define TCD_FN_COPY 8'h48
`define TCD_RELOAD_TRIGGERS_CMD 8'hb8
`define TCD_FN_POWER_QUERY 8'hb4

// ----------------------------------------------------------------
// sizes and counts
// ----------------------------------------------------------------
`define TCD_ID_BITS 7'd64
`define TCD_SPAD_BYTES 4'd9
`define TCD_SPAD_TH 4'd2
`define TCD_SPAD_TL 4'd3
`define TCD_SPAD_TEMP_LO 4'd0
`define TCD_SPAD_TEMP_HI 4'd1
`define TCD_SPAD_CRC 4'd8

`endif

/* rtl/tcd_pkg.sv */
// types shared by the thermometer command decoder files
package tcd_pkg;

	// ----------------------------------------------------------------
	// decoder states, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [8:0] {
		TCD_ST_WAIT_RESET = 9'h001, // silent until next bus reset
		TCD_ST_ROM = 9'h002, // receiving rom command
		TCD_ST_READ_ID = 9'h004, // sending identifier
		TCD_ST_MATCH = 9'h008, // comparing identifier
		TCD_ST_FUNC = 9'h010, // receiving function command
		TCD_ST_READ_SPAD = 9'h020, // sending scratchpad
		TCD_ST_WRITE_SPAD = 9'h040, // receiving trigger bytes
		TCD_ST_STATUS = 9'h080, // answering busy status
		TCD_ST_POWER = 9'h100 // answering power mode
	} tcd_state_t;

	// which operation a status read slot reports
	typedef enum logic [1:0] {
		TCD_SEL_CONV = 2'b01,
		TCD_SEL_RECALL = 2'b10
	} tcd_stat_sel_t;

endpackage

/* rtl/tcd_spad_mem.sv */
// nine byte scratchpad store with registered read data
`timescale 1ns/100ps
`include "tcd_params.svh"

module tcd_spad_mem (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire logic [3:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [3:0] rd_addr,
	output logic [7:0] rd_data
);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [71:0] mem; // byte n at bits 8n+7:8n

	// write port, reset to defined contents
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem <= `TCD_SPAD_RESET;
		end else if (wr_en && wr_addr < `TCD_SPAD_BYTES) begin
			mem[wr_addr*8 +: 8] <= wr_data;
		end
	end

	// registered read, out of range reads as zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_data <= 8'h00;
		end else if (rd_addr < `TCD_SPAD_BYTES) begin
			rd_data <= mem[rd_addr*8 +: 8];
		end else begin
			rd_data <= 8'h00;
		end
	end

endmodule

/* tb/tcd_props.sv */
// port assertions for the thermometer command decoder
`timescale 1ns/100ps
module tcd_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic bus_reset,
	input wire logic rd_bit,
	input wire logic search_start,
	input wire logic conv_start,
	input wire logic copy_start,
	input wire tcd_pkg::tcd_state_t dec_state
);
	import tcd_pkg::*;
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// decoder held silent long enough for rd_bit to settle
	sequence s_silent4;
		(dec_state == TCD_ST_WAIT_RESET)[*4];
	endsequence
	// any start pulse
	sequence s_any_start;
		conv_start || copy_start || search_start;
	endsequence
	property p_conv;
		conv_start |-> dec_state == TCD_ST_STATUS;
	endproperty
	a_conv: assert property (p_conv) else $error("conv start outside status stage");
	property p_copy;
		copy_start |-> dec_state == TCD_ST_WAIT_RESET;
	endproperty
	a_copy: assert property (p_copy) else $error("copy not followed by silence");
	property p_search;
		search_start |-> dec_state == TCD_ST_WAIT_RESET;
	endproperty
	a_search: assert property (p_search) else $error("search not followed by silence");
	property p_reset_rom;
		bus_reset |=> dec_state == TCD_ST_ROM;
	endproperty
	a_reset_rom: assert property (p_reset_rom) else $error("bus reset missed");
	property p_silent;
		dec_state == TCD_ST_WAIT_RESET && !bus_reset |=> dec_state == TCD_ST_WAIT_RESET;
	endproperty
	a_silent: assert property (p_silent) else $error("left silence without reset");
	property p_idle;
		s_silent4 |-> rd_bit;
	endproperty
	a_idle: assert property (p_idle) else $error("line driven while silent");
	property p_pulse;
		s_any_start |=> !(conv_start || copy_start || search_start);
	endproperty
	a_pulse: assert property (p_pulse) else $error("start pulse too long");
	property p_order;
		$changed(dec_state) && dec_state inside {TCD_ST_STATUS, TCD_ST_READ_SPAD,
			TCD_ST_WRITE_SPAD, TCD_ST_POWER} |-> $past(dec_state) == TCD_ST_FUNC;
	endproperty
	a_order: assert property (p_order) else $error("function stage skipped");
	property p_func;
		$changed(dec_state) && dec_state == TCD_ST_FUNC
			|-> $past(dec_state) inside {TCD_ST_ROM, TCD_ST_READ_ID, TCD_ST_MATCH};
	endproperty
	a_func: assert property (p_func) else $error("function stage without rom stage");
endmodule

/* tb/tcd_line_master.sv */
// bit layer model of the bus master: resets, write slots, read slots
`timescale 1ns/100ps
module tcd_line_master (
	input wire logic pclk,
	input wire logic rd_bit,
	output logic bus_reset,
	output logic wr_bit_valid,
	output logic wr_bit,
	output logic rd_slot
);
	initial begin
		bus_reset = 1'b0;
		wr_bit_valid = 1'b0;
		wr_bit = 1'b0;
		rd_slot = 1'b0;
	end
	// one slot pulse, then a gap so rd_bit can settle; data inverted outside slot
	task automatic slot(input logic v, input logic rd, input logic rst);
		@(posedge pclk);
		bus_reset <= rst;
		wr_bit_valid <= !(rd || rst);
		rd_slot <= rd;
		wr_bit <= v;
		@(posedge pclk);
		bus_reset <= 1'b0;
		wr_bit_valid <= 1'b0;
		rd_slot <= 1'b0;
		wr_bit <= ~v;
		repeat (3) @(posedge pclk);
	endtask
	// byte and identifier sends, least significant bit first
	task automatic put8(input logic [7:0] b);
		for (int i = 0; i < 8; i++) slot(b[i], 1'b0, 1'b0);
	endtask
	task automatic put64(input logic [63:0] b);
		for (int i = 0; i < 64; i++) slot(b[i], 1'b0, 1'b0);
	endtask
	// initialization followed by a rom command
	task automatic start(input logic [7:0] rom);
		slot(1'b0, 1'b0, 1'b1);
		put8(rom);
	endtask
	// n read slots, first bit lands in bit 0
	task automatic get(input int n, output logic [63:0] d);
		d = '1;
		for (int i = 0; i < n; i++) begin
			d[i] = rd_bit;
			slot(1'b1, 1'b1, 1'b0);
		end
	endtask
endmodule

/* tb/tb.sv */
// self-checking bench for the thermometer command decoder
`timescale 1ns/100ps
`include "tcd_params.svh"
module tb;
	import tcd_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_bit, err;
	logic alarm_flag, conv_busy, temp_valid, search_start, search_alarm, conv_start, copy_start;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] temp_data;
	logic [7:0] nv_th, nv_tl, crc_in, copy_th, copy_tl;
	logic [63:0] d;
	logic bus_reset, wr_bit_valid, wr_bit, rd_slot;
	tcd_state_t dec_state;
	int n_errors = 0;
	int checks = 0;
	// rom command, function command, stage that should follow
	typedef struct {logic [7:0] rom; logic [7:0] fn; tcd_state_t st;} tcd_row_t;
	tcd_row_t rows [9] = '{
		'{`TCD_ROM_SKIP, `TCD_FN_CONVERT, TCD_ST_STATUS},
		'{`TCD_ROM_SKIP, `TCD_FN_READ_SPAD, TCD_ST_READ_SPAD},
		'{`TCD_ROM_SKIP, `TCD_FN_COPY, TCD_ST_WAIT_RESET},
		'{`TCD_ROM_SKIP, `TCD_RELOAD_TRIGGERS_CMD, TCD_ST_STATUS},
		'{`TCD_ROM_SKIP, `TCD_FN_POWER_QUERY, TCD_ST_POWER},
		'{`TCD_ROM_SKIP, 8'h5a, TCD_ST_WAIT_RESET},
		'{`TCD_ROM_SEARCH, `TCD_FN_CONVERT, TCD_ST_WAIT_RESET},
		'{`TCD_ROM_ALARM_SEARCH, `TCD_FN_CONVERT, TCD_ST_WAIT_RESET},
		'{8'h3c, `TCD_FN_CONVERT, TCD_ST_WAIT_RESET}};
	tcd_decoder u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus_reset(bus_reset), .wr_bit_valid(wr_bit_valid),
		.wr_bit(wr_bit), .rd_slot(rd_slot), .rd_bit(rd_bit), .alarm_flag(alarm_flag),
		.search_start(search_start), .search_alarm(search_alarm), .conv_start(conv_start),
		.conv_busy(conv_busy), .temp_valid(temp_valid), .temp_data(temp_data),
		.copy_start(copy_start), .copy_th(copy_th), .copy_tl(copy_tl), .nv_th(nv_th),
		.nv_tl(nv_tl), .crc_in(crc_in), .dec_state(dec_state));
	tcd_line_master u_master (.pclk(pclk), .rd_bit(rd_bit), .bus_reset(bus_reset),
		.wr_bit_valid(wr_bit_valid), .wr_bit(wr_bit), .rd_slot(rd_slot));
	// ----------------------------------------------------------------
	// clock, compare, apb and closing tasks
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic final_report;
		if (n_errors == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// watchdog against a hung handshake
	initial begin
		repeat (60000) @(posedge pclk);
		n_errors++;
		final_report;
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, conv_busy, temp_valid} = '0;
		{alarm_flag, nv_th, nv_tl, crc_in, temp_data} = {1'b1, 24'h5aa57e, 16'h1234};
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		chk("state", dec_state, TCD_ST_WAIT_RESET);
		chk("rd_bit", rd_bit, 1'b1);
		apb(1'b0, 12'h014, 32'h0);
		chk("slverr", err, 1'b1);
		apb(1'b0, `TCD_OFS_TRIG, 32'h0);
		chk("trig", rd, 32'h0000_a55a);
		apb(1'b1, `TCD_OFS_ID_LO, 32'h89ab_cdef);
		apb(1'b1, `TCD_OFS_ID_HI, 32'h0123_4567);
		foreach (rows[i]) begin
			u_master.start(rows[i].rom);
			u_master.put8(rows[i].fn);
			chk("state", dec_state, rows[i].st);
		end
		u_master.start(`TCD_ROM_READ);
		u_master.get(64, d);
		chk("id", d, 64'h0123_4567_89ab_cdef);
		u_master.start(`TCD_ROM_MATCH);
		u_master.put64(64'h0123_4567_89ab_cdef);
		chk("state", dec_state, TCD_ST_FUNC);
		u_master.start(`TCD_ROM_MATCH);
		u_master.put64(64'h8123_4567_89ab_cdef);
		u_master.put8(`TCD_FN_READ_SPAD);
		u_master.get(8, d);
		chk("silent", d[7:0], 8'hff);
		u_master.start(`TCD_ROM_SKIP);
		u_master.put8(`TCD_FN_WRITE_SPAD);
		u_master.put8(8'h3c);
		u_master.put8(8'hc3);
		apb(1'b0, `TCD_OFS_TRIG, 32'h0);
		chk("trig", rd, 32'h0000_c33c);
		temp_valid <= 1'b1;
		@(posedge pclk);
		temp_valid <= 1'b0;
		u_master.start(`TCD_ROM_SKIP);
		u_master.put8(`TCD_FN_READ_SPAD);
		u_master.get(64, d);
		chk("spad", d, 64'hffff_0000_c33c_1234);
		u_master.get(8, d);
		chk("crc", d[7:0], 8'h7e);
		u_master.start(`TCD_ROM_SKIP);
		u_master.put8(`TCD_FN_READ_SPAD);
		u_master.get(8, d);
		u_master.slot(1'b0, 1'b0, 1'b1);
		chk("state", dec_state, TCD_ST_ROM);
		repeat (3) u_master.slot(1'b1, 1'b0, 1'b0);
		conv_busy <= 1'b1;
		for (int p = 0; p < 2; p++) begin
			apb(1'b1, `TCD_OFS_CTRL, p);
			u_master.start(`TCD_ROM_SKIP);
			u_master.put8(`TCD_FN_CONVERT);
			u_master.get(1, d);
			chk("busy", d[0], p[0]);
			u_master.start(`TCD_ROM_SKIP);
			u_master.put8(`TCD_FN_POWER_QUERY);
			u_master.get(1, d);
			chk("power", d[0], !p[0]);
		end
		apb(1'b1, `TCD_OFS_CTRL, 32'h0);
		conv_busy <= 1'b0;
		{nv_th, nv_tl} <= 16'h1122;
		u_master.start(`TCD_ROM_SKIP);
		u_master.put8(`TCD_RELOAD_TRIGGERS_CMD);
		repeat (20) @(posedge pclk);
		u_master.get(1, d);
		chk("reload", d[0], 1'b1);
		apb(1'b0, `TCD_OFS_TRIG, 32'h0);
		chk("trig", rd, 32'h0000_2211);
		u_master.start(`TCD_ROM_SKIP);
		u_master.put8(`TCD_FN_COPY);
		repeat (50) @(posedge pclk);
		chk("copy", {copy_tl, copy_th}, 16'h2211);
		final_report;
	end
endmodule
bind tcd_decoder tcd_props u_props (.pclk(pclk), .presetn(presetn), .bus_reset(bus_reset),
	.rd_bit(rd_bit), .search_start(search_start), .conv_start(conv_start),
	.copy_start(copy_start), .dec_state(dec_state));
